// ==== hw/pfm_pkg.sv ====
// Shared constants, types and register map of the PFC fault monitor.
package pfm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DW    = 16;
  localparam int AW    = 8;
  localparam int SW    = 12;
  localparam int FLT_W = 6;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFF_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFF_STATE   = 8'h04;
  localparam logic [AW-1:0] OFF_FLAGS   = 8'h08;
  localparam logic [AW-1:0] OFF_ENABLE  = 8'h0C;
  localparam logic [AW-1:0] OFF_SWFLT   = 8'h10;
  localparam logic [AW-1:0] OFF_DC_RAW  = 8'h14;
  localparam logic [AW-1:0] OFF_DC_FILT = 8'h18;
  localparam logic [AW-1:0] OFF_AC_RMS  = 8'h1C;
  localparam logic [AW-1:0] OFF_DC_UV   = 8'h20;
  localparam logic [AW-1:0] OFF_DC_OV   = 8'h24;
  localparam logic [AW-1:0] OFF_AC_OV   = 8'h28;
  localparam logic [AW-1:0] OFF_AC_UV   = 8'h2C;
  localparam logic [AW-1:0] OFF_IRQ_STS = 8'h30;
  localparam logic [AW-1:0] OFF_IRQ_MSK = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN   = 0;
  localparam int CTL_CLEAR = 1;
  localparam int CTL_NOM60 = 2;
  localparam int FLT_DC_UV = 1;
  localparam int FLT_DC_OV = 2;
  localparam int FLT_FREQ  = 3;
  localparam int FLT_AC_UV = 4;
  localparam int FLT_AC_OV = 5;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_FLAG  = 1;
  localparam int IRQ_REJ   = 2;

  // ----------------------------------------------------------------
  // Unmaskable fault set and reset values
  // ----------------------------------------------------------------
  localparam logic [FLT_W-1:0] FLT_UNMASKABLE = 6'h08;
  localparam logic [FLT_W-1:0] RST_ENABLE     = 6'h36;
  localparam logic [SW-1:0]    RST_DC_UV      = 12'h200;
  localparam logic [SW-1:0]    RST_DC_OV      = 12'hE00;
  localparam logic [SW-1:0]    RST_AC_OV      = 12'h600;
  localparam logic [SW-1:0]    RST_AC_UV      = 12'h100;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 100;
  localparam int SEQ_TICK_NS  = 1000000;
  localparam int SEQ_TICK_CYC = SEQ_TICK_NS / CLK_NS;
  localparam int NOM50_MIN_HZ = 45;
  localparam int NOM50_MAX_HZ = 55;
  localparam int NOM60_MIN_HZ = 55;
  localparam int NOM60_MAX_HZ = 65;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_STOP, ST_RUN, ST_FAULT} pfm_state_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } pfm_bus_req_t;

  typedef struct packed {
    logic                 tick;
    logic [SW-1:0]        dc;
    logic signed [SW-1:0] ac;
  } pfm_sense_t;

endpackage : pfm_pkg

// ==== hw/pfm_lpf.sv ====
// First-order low-pass filter stepped once per PWM cycle.
module pfm_lpf #(
  parameter int W     = 12,
  parameter int SHIFT = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Samples
  input  wire logic         en,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] filt
);

  logic [W+SHIFT-1:0] acc_q;
  logic [W+SHIFT-1:0] acc_d;

  always_comb
  begin
    acc_d = acc_q;
    if (en)
    begin
      acc_d = acc_q + (W+SHIFT)'(raw) - (acc_q >> SHIFT);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= '0;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  assign filt = acc_q[W+SHIFT-1:SHIFT];

endmodule : pfm_lpf

// ==== hw/pfm_rms.sv ====
// Mean-square filter of the AC input with a square root at each update.
module pfm_rms #(
  parameter int W     = 12,
  parameter int SHIFT = 6
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Samples and update
  input  wire logic                en,
  input  wire logic signed [W-1:0] ac,
  input  wire logic                upd,
  output logic             [W-1:0] rms
);

  logic [2*W+SHIFT-1:0] ms_q;
  logic [2*W+SHIFT-1:0] ms_d;
  logic [W-1:0]         rms_q;
  logic [W-1:0]         rms_d;
  logic [W-1:0]         mag;

  function automatic logic [W-1:0] isqrt(input logic [2*W-1:0] v);
    logic [W-1:0] r;
    logic [W-1:0] c;
    r = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      c = r | (W'(1) << i);
      if ({{W{1'b0}}, c} * {{W{1'b0}}, c} <= v)
      begin
        r = c;
      end
    end
    return r;
  endfunction : isqrt

  always_comb
  begin
    mag   = ac[W-1] ? W'(-ac) : W'(ac);
    ms_d  = ms_q;
    rms_d = rms_q;
    if (en)
    begin
      ms_d = ms_q + (2*W+SHIFT)'(mag * mag) - (ms_q >> SHIFT);
    end
    if (upd)
    begin
      rms_d = isqrt(ms_q[2*W+SHIFT-1:SHIFT]);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_q  <= '0;
      rms_q <= '0;
    end
    else
    begin
      ms_q  <= ms_d;
      rms_q <= rms_d;
    end
  end

  assign rms = rms_q;

endmodule : pfm_rms

// ==== hw/pfm_monitor.sv ====
// PFC voltage and line frequency fault monitor with its sequencer.
// Behaviour
// RQ1 - Sample DC bus each PWM cycle; raw and filtered values readable separately.
// RQ2 - DC filter time constant follows PWM rate, stepped once per PWM cycle.
// RQ3 - Filtered DC below under-voltage threshold sets flag bit 1.
// RQ4 - Filtered DC above over-voltage threshold sets flag bit 2.
// RQ5 - Enabled maskable fault reaches software word, enters FAULT, stops PFC.
// RQ6 - Disabled maskable fault stays out of software word; sequencer unaffected.
// RQ7 - Writing clear once conditions are gone moves the sequencer to STOP.
// RQ8 - AC sampled each PWM cycle; RMS recomputed at every 1 ms update.
// RQ9 - AC RMS above over-voltage threshold sets flag bit 5, mask bit 5.
// RQ10 - AC RMS below under-voltage threshold sets flag bit 4, mask bit 4.
// RQ11 - Frequency limits 45 to 55 Hz at 50 Hz, 55 to 65 Hz at 60 Hz.
// RQ12 - Half cycle shorter than minimum at update sets unmaskable bit 3, FAULT.
// RQ13 - Half cycle counter past maximum before zero crossing sets bit 3, FAULT.
// RQ14 - PFC stops whenever the motor control section reports a fault.
// RQ15 - Sequencer steps once every 1 ms.
// RQ16 - Software issues run command 1 after a clear to restart the PFC.
// RQ17 - A clear while any fault condition persists is ignored; FAULT stays. Here only enabled or unmaskable conditions block the clear.
//
// The address map and strobed register access were chosen for this implementation.
module pfm_monitor #(
  parameter int SEQ_TICK_CYCLES = pfm_pkg::SEQ_TICK_CYC,
  parameter int PWM_HZ          = 20000,
  parameter int LPF_SHIFT       = 4,
  parameter int RMS_SHIFT       = 6,
  parameter int CNT_W           = 16
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESETN,
  // Register port
  input  wire pfm_pkg::pfm_bus_req_t BUS,
  output logic [pfm_pkg::DW-1:0]     RDATA,
  // Sensing and motor status
  input  wire pfm_pkg::pfm_sense_t   SENSE,
  input  wire logic                  MOTOR_FAULT,
  // Control outputs
  output logic                       PFC_RUN,
  output logic                       IRQ
);

  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] MIN50 = CNT_W'(PWM_HZ / (2 * pfm_pkg::NOM50_MAX_HZ));
  localparam logic [CNT_W-1:0] MAX50 = CNT_W'(PWM_HZ / (2 * pfm_pkg::NOM50_MIN_HZ));
  localparam logic [CNT_W-1:0] MIN60 = CNT_W'(PWM_HZ / (2 * pfm_pkg::NOM60_MAX_HZ));
  localparam logic [CNT_W-1:0] MAX60 = CNT_W'(PWM_HZ / (2 * pfm_pkg::NOM60_MIN_HZ));
  localparam int TW = $clog2(SEQ_TICK_CYCLES + 1);

  logic [TW-1:0]              tick_cnt_q;
  logic [TW-1:0]              tick_cnt_d;
  logic                       seq_tick;
  logic [pfm_pkg::SW-1:0]     dc_raw_q;
  logic [pfm_pkg::SW-1:0]     dc_raw_d;
  logic [pfm_pkg::SW-1:0]     dc_bus_filtered;
  logic [pfm_pkg::SW-1:0]     ac_rms;
  logic                       sign_q;
  logic                       sign_d;
  logic                       zc_seen_q;
  logic                       zc_seen_d;
  logic                       primed_q;
  logic                       primed_d;
  logic [CNT_W-1:0]           half_cnt_q;
  logic [CNT_W-1:0]           half_cnt_d;
  logic [CNT_W-1:0]           half_len_q;
  logic [CNT_W-1:0]           half_len_d;
  logic                       short_q;
  logic                       short_d;
  logic [CNT_W-1:0]           half_min;
  logic [CNT_W-1:0]           half_max;
  logic                       crossing;
  logic [pfm_pkg::FLT_W-1:0]  cond;
  logic [pfm_pkg::FLT_W-1:0]  gate;
  pfm_pkg::pfm_state_t        state_q;
  pfm_pkg::pfm_state_t        state_d;
  logic [pfm_pkg::FLT_W-1:0]  fault_flag_word_q;
  logic [pfm_pkg::FLT_W-1:0]  fault_flag_word_d;
  logic [pfm_pkg::FLT_W-1:0]  fault_enable_mask_q;
  logic [pfm_pkg::FLT_W-1:0]  fault_enable_mask_d;
  logic [pfm_pkg::FLT_W-1:0]  software_fault_word_q;
  logic [pfm_pkg::FLT_W-1:0]  software_fault_word_d;
  logic                       run_command_q;
  logic                       run_command_d;
  logic                       fault_clear_request_q;
  logic                       fault_clear_request_d;
  logic                       nom60_q;
  logic                       nom60_d;
  logic [pfm_pkg::SW-1:0]     dc_under_voltage_threshold_q;
  logic [pfm_pkg::SW-1:0]     dc_under_voltage_threshold_d;
  logic [pfm_pkg::SW-1:0]     dc_over_voltage_threshold_q;
  logic [pfm_pkg::SW-1:0]     dc_over_voltage_threshold_d;
  logic [pfm_pkg::SW-1:0]     ac_over_voltage_threshold_q;
  logic [pfm_pkg::SW-1:0]     ac_over_voltage_threshold_d;
  logic [pfm_pkg::SW-1:0]     ac_under_voltage_threshold_q;
  logic [pfm_pkg::SW-1:0]     ac_under_voltage_threshold_d;
  logic [pfm_pkg::IRQ_W-1:0]  irq_sts_q;
  logic [pfm_pkg::IRQ_W-1:0]  irq_sts_d;
  logic [pfm_pkg::IRQ_W-1:0]  irq_msk_q;
  logic [pfm_pkg::IRQ_W-1:0]  irq_msk_d;
  logic [pfm_pkg::IRQ_W-1:0]  irq_ev;
  logic [pfm_pkg::DW-1:0]     rdata_d;
  logic                       run_d;
  logic                       irq_d;

  // ----------------------------------------------------------------
  // Filters
  // ----------------------------------------------------------------
  // RQ2 filter per PWM
  pfm_lpf #(.W(pfm_pkg::SW), .SHIFT(LPF_SHIFT)) u_lpf (
    .clk   (CLK),
    .rst_n (RESETN),
    .en    (SENSE.tick),
    .raw   (SENSE.dc),
    .filt  (dc_bus_filtered)
  );

  // RQ8 RMS per update
  pfm_rms #(.W(pfm_pkg::SW), .SHIFT(RMS_SHIFT)) u_rms (
    .clk   (CLK),
    .rst_n (RESETN),
    .en    (SENSE.tick),
    .ac    (SENSE.ac),
    .upd   (seq_tick),
    .rms   (ac_rms)
  );

  // ----------------------------------------------------------------
  // Tick and line frequency
  // ----------------------------------------------------------------
  always_comb
  begin
    // RQ15 one ms tick
    seq_tick   = (tick_cnt_q == TW'(SEQ_TICK_CYCLES - 1));
    tick_cnt_d = seq_tick ? '0 : tick_cnt_q + TW'(1);
    // RQ1 raw DC sample
    dc_raw_d   = SENSE.tick ? SENSE.dc : dc_raw_q;
    // RQ11 limits by nominal
    half_min   = nom60_q ? MIN60 : MIN50;
    half_max   = nom60_q ? MAX60 : MAX50;
    // The first sample only primes the sign, so reset cannot fake a crossing.
    primed_d   = primed_q | SENSE.tick;
    crossing   = SENSE.tick && primed_q && (~SENSE.ac[pfm_pkg::SW-1] != sign_q);
    sign_d     = SENSE.tick ? ~SENSE.ac[pfm_pkg::SW-1] : sign_q;
    zc_seen_d  = zc_seen_q | crossing;
    half_len_d = (crossing && zc_seen_q) ? half_cnt_q : half_len_q;
    half_cnt_d = half_cnt_q;
    if (crossing)
    begin
      half_cnt_d = '0;
    end
    else if (SENSE.tick && (half_cnt_q != '1))
    begin
      half_cnt_d = half_cnt_q + CNT_W'(1);
    end
    // RQ12 minimum at update
    short_d = seq_tick ? (half_len_q < half_min) : short_q;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tick_cnt_q <= '0;
      dc_raw_q   <= '0;
      sign_q     <= 1'b0;
      zc_seen_q  <= 1'b0;
      primed_q   <= 1'b0;
      half_cnt_q <= '0;
      half_len_q <= '1;
      short_q    <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      dc_raw_q   <= dc_raw_d;
      sign_q     <= sign_d;
      zc_seen_q  <= zc_seen_d;
      primed_q   <= primed_d;
      half_cnt_q <= half_cnt_d;
      half_len_q <= half_len_d;
      short_q    <= short_d;
    end
  end

  // ----------------------------------------------------------------
  // Faults, sequencer and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    cond = '0;
    // RQ3 DC under-voltage
    cond[pfm_pkg::FLT_DC_UV] = dc_bus_filtered < dc_under_voltage_threshold_q;
    // RQ4 DC over-voltage
    cond[pfm_pkg::FLT_DC_OV] = dc_bus_filtered > dc_over_voltage_threshold_q;
    // RQ13 maximum half cycle
    cond[pfm_pkg::FLT_FREQ]  = short_q || (half_cnt_q > half_max);
    // RQ10 AC under-voltage
    cond[pfm_pkg::FLT_AC_UV] = ac_rms < ac_under_voltage_threshold_q;
    // RQ9 AC over-voltage
    cond[pfm_pkg::FLT_AC_OV] = ac_rms > ac_over_voltage_threshold_q;
    gate = fault_enable_mask_q | pfm_pkg::FLT_UNMASKABLE;

    fault_flag_word_d            = fault_flag_word_q | cond;
    fault_enable_mask_d          = fault_enable_mask_q;
    run_command_d                = run_command_q;
    fault_clear_request_d        = fault_clear_request_q;
    nom60_d                      = nom60_q;
    dc_under_voltage_threshold_d = dc_under_voltage_threshold_q;
    dc_over_voltage_threshold_d  = dc_over_voltage_threshold_q;
    ac_over_voltage_threshold_d  = ac_over_voltage_threshold_q;
    ac_under_voltage_threshold_d = ac_under_voltage_threshold_q;
    irq_msk_d                    = irq_msk_q;
    state_d                      = state_q;
    irq_ev                       = '0;
    irq_ev[pfm_pkg::IRQ_FLAG]    = |(cond & ~fault_flag_word_q);

    if (BUS.wr)
    begin
      case (BUS.addr)
        pfm_pkg::OFF_CTRL:
        begin
          run_command_d         = BUS.wdata[pfm_pkg::CTL_RUN];
          nom60_d               = BUS.wdata[pfm_pkg::CTL_NOM60];
          fault_clear_request_d = fault_clear_request_q | BUS.wdata[pfm_pkg::CTL_CLEAR];
        end
        pfm_pkg::OFF_ENABLE:  fault_enable_mask_d = BUS.wdata[pfm_pkg::FLT_W-1:0];
        pfm_pkg::OFF_DC_UV:   dc_under_voltage_threshold_d = BUS.wdata[pfm_pkg::SW-1:0];
        pfm_pkg::OFF_DC_OV:   dc_over_voltage_threshold_d = BUS.wdata[pfm_pkg::SW-1:0];
        pfm_pkg::OFF_AC_OV:   ac_over_voltage_threshold_d = BUS.wdata[pfm_pkg::SW-1:0];
        pfm_pkg::OFF_AC_UV:   ac_under_voltage_threshold_d = BUS.wdata[pfm_pkg::SW-1:0];
        pfm_pkg::OFF_IRQ_MSK: irq_msk_d = BUS.wdata[pfm_pkg::IRQ_W-1:0];
        default:              irq_msk_d = irq_msk_q;
      endcase
    end

    if (seq_tick)
    begin
      fault_clear_request_d = BUS.wr && (BUS.addr == pfm_pkg::OFF_CTRL)
                              && BUS.wdata[pfm_pkg::CTL_CLEAR];
      // RQ5 enabled fault enters FAULT
      if (|software_fault_word_q && (state_q != pfm_pkg::ST_FAULT))
      begin
        state_d                    = pfm_pkg::ST_FAULT;
        run_command_d              = 1'b0;
        irq_ev[pfm_pkg::IRQ_FAULT] = 1'b1;
      end
      else
      begin
        case (state_q)
          pfm_pkg::ST_IDLE: state_d = pfm_pkg::ST_STOP;
          // RQ16 run command restarts
          pfm_pkg::ST_STOP: state_d = run_command_q ? pfm_pkg::ST_RUN : pfm_pkg::ST_STOP;
          pfm_pkg::ST_RUN:  state_d = run_command_q ? pfm_pkg::ST_RUN : pfm_pkg::ST_STOP;
          pfm_pkg::ST_FAULT:
          begin
            if (fault_clear_request_q)
            begin
              // RQ7 successful clear
              if (!(|(cond & gate)))
              begin
                state_d           = pfm_pkg::ST_STOP;
                fault_flag_word_d = cond;
              end
              // RQ17 clear ignored
              else
              begin
                irq_ev[pfm_pkg::IRQ_REJ] = 1'b1;
              end
            end
          end
          default: state_d = pfm_pkg::ST_IDLE;
        endcase
      end
    end

    // RQ6 mask gates software word
    software_fault_word_d = fault_flag_word_d & gate;
    irq_sts_d = irq_sts_q | irq_ev;
    if (BUS.wr && (BUS.addr == pfm_pkg::OFF_IRQ_STS))
    begin
      irq_sts_d = (irq_sts_q & ~BUS.wdata[pfm_pkg::IRQ_W-1:0]) | irq_ev;
    end
    irq_d = |(irq_sts_d & irq_msk_d);
    // RQ14 motor fault stops PFC
    run_d = (state_d == pfm_pkg::ST_RUN) && !MOTOR_FAULT;

    rdata_d = '0;
    if (BUS.rd)
    begin
      case (BUS.addr)
        pfm_pkg::OFF_CTRL:    rdata_d = pfm_pkg::DW'({nom60_q, fault_clear_request_q,
                                                      run_command_q});
        pfm_pkg::OFF_STATE:   rdata_d = pfm_pkg::DW'(state_q);
        pfm_pkg::OFF_FLAGS:   rdata_d = pfm_pkg::DW'(fault_flag_word_q);
        pfm_pkg::OFF_ENABLE:  rdata_d = pfm_pkg::DW'(fault_enable_mask_q);
        pfm_pkg::OFF_SWFLT:   rdata_d = pfm_pkg::DW'(software_fault_word_q);
        pfm_pkg::OFF_DC_RAW:  rdata_d = pfm_pkg::DW'(dc_raw_q);
        pfm_pkg::OFF_DC_FILT: rdata_d = pfm_pkg::DW'(dc_bus_filtered);
        pfm_pkg::OFF_AC_RMS:  rdata_d = pfm_pkg::DW'(ac_rms);
        pfm_pkg::OFF_DC_UV:   rdata_d = pfm_pkg::DW'(dc_under_voltage_threshold_q);
        pfm_pkg::OFF_DC_OV:   rdata_d = pfm_pkg::DW'(dc_over_voltage_threshold_q);
        pfm_pkg::OFF_AC_OV:   rdata_d = pfm_pkg::DW'(ac_over_voltage_threshold_q);
        pfm_pkg::OFF_AC_UV:   rdata_d = pfm_pkg::DW'(ac_under_voltage_threshold_q);
        pfm_pkg::OFF_IRQ_STS: rdata_d = pfm_pkg::DW'(irq_sts_q);
        pfm_pkg::OFF_IRQ_MSK: rdata_d = pfm_pkg::DW'(irq_msk_q);
        default:              rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q                      <= pfm_pkg::ST_IDLE;
      fault_flag_word_q            <= '0;
      fault_enable_mask_q          <= pfm_pkg::RST_ENABLE;
      software_fault_word_q        <= '0;
      run_command_q                <= 1'b0;
      fault_clear_request_q        <= 1'b0;
      nom60_q                      <= 1'b0;
      dc_under_voltage_threshold_q <= pfm_pkg::RST_DC_UV;
      dc_over_voltage_threshold_q  <= pfm_pkg::RST_DC_OV;
      ac_over_voltage_threshold_q  <= pfm_pkg::RST_AC_OV;
      ac_under_voltage_threshold_q <= pfm_pkg::RST_AC_UV;
      irq_sts_q                    <= '0;
      irq_msk_q                    <= '0;
      RDATA                        <= '0;
      PFC_RUN                      <= 1'b0;
      IRQ                          <= 1'b0;
    end
    else
    begin
      state_q                      <= state_d;
      fault_flag_word_q            <= fault_flag_word_d;
      fault_enable_mask_q          <= fault_enable_mask_d;
      software_fault_word_q        <= software_fault_word_d;
      run_command_q                <= run_command_d;
      fault_clear_request_q        <= fault_clear_request_d;
      nom60_q                      <= nom60_d;
      dc_under_voltage_threshold_q <= dc_under_voltage_threshold_d;
      dc_over_voltage_threshold_q  <= dc_over_voltage_threshold_d;
      ac_over_voltage_threshold_q  <= ac_over_voltage_threshold_d;
      ac_under_voltage_threshold_q <= ac_under_voltage_threshold_d;
      irq_sts_q                    <= irq_sts_d;
      irq_msk_q                    <= irq_msk_d;
      RDATA                        <= rdata_d;
      PFC_RUN                      <= run_d;
      IRQ                          <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_dc_uv;
    cond[pfm_pkg::FLT_DC_UV] |=> fault_flag_word_q[pfm_pkg::FLT_DC_UV];
  endproperty
  a_dc_uv: assert property (p_dc_uv) else $error("DC under-voltage flag missing"); // RQ3

  property p_dc_ov;
    (dc_bus_filtered > dc_over_voltage_threshold_q) |=> fault_flag_word_q[pfm_pkg::FLT_DC_OV];
  endproperty
  a_dc_ov: assert property (p_dc_ov) else $error("DC over-voltage flag missing"); // RQ4

  property p_ac_ov;
    (ac_rms > ac_over_voltage_threshold_q) |=> fault_flag_word_q[pfm_pkg::FLT_AC_OV];
  endproperty
  a_ac_ov: assert property (p_ac_ov) else $error("AC over-voltage flag missing"); // RQ9

  property p_masked;
    ##1 (software_fault_word_q & ~($past(fault_enable_mask_q) | pfm_pkg::FLT_UNMASKABLE)) == '0;
  endproperty
  a_masked: assert property (p_masked) else $error("Masked fault in software word"); // RQ6

  property p_enter_fault;
    (seq_tick && |software_fault_word_q && state_q != pfm_pkg::ST_FAULT)
      |=> (state_q == pfm_pkg::ST_FAULT) && !PFC_RUN;
  endproperty
  a_enter_fault: assert property (p_enter_fault) else $error("Fault not entered"); // RQ5

  property p_clear_ok;
    (seq_tick && state_q == pfm_pkg::ST_FAULT && fault_clear_request_q && !(|(cond & gate)))
      |=> state_q == pfm_pkg::ST_STOP;
  endproperty
  a_clear_ok: assert property (p_clear_ok) else $error("Clear did not reach STOP"); // RQ7

  property p_clear_rej;
    (seq_tick && state_q == pfm_pkg::ST_FAULT && |(cond & gate)) |=> state_q == pfm_pkg::ST_FAULT;
  endproperty
  a_clear_rej: assert property (p_clear_rej) else $error("Clear accepted with fault"); // RQ17

  property p_state_on_tick;
    (state_q != $past(state_q)) |-> $past(seq_tick);
  endproperty
  a_state_on_tick: assert property (p_state_on_tick) else $error("State moved off tick"); // RQ15

  property p_motor;
    MOTOR_FAULT |=> !PFC_RUN;
  endproperty
  a_motor: assert property (p_motor) else $error("PFC runs during motor fault"); // RQ14

  property p_freq_max;
    (half_cnt_q > half_max) |=> fault_flag_word_q[pfm_pkg::FLT_FREQ] ##1
      fault_flag_word_q[pfm_pkg::FLT_FREQ] || state_q == pfm_pkg::ST_STOP;
  endproperty
  a_freq_max: assert property (p_freq_max) else $error("Half cycle overrun not flagged"); // RQ13

endmodule : pfm_monitor

// ==== tb/pfm_sense_model.sv ====
// Behavioural DC bus and AC line sensing front end.
module pfm_sense_model
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Analog levels
  input  wire logic [11:0]    dc_lvl,
  input  wire logic [11:0]    ac_amp,
  output pfm_pkg::pfm_sense_t sense
);
  timeunit 1ns;
  timeprecision 1ns;
  int   pwm_cnt;
  int   half_cnt;
  logic pol;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_cnt <= 0;
      half_cnt <= 0;
      pol <= 1'b0;
      sense <= '0;
    end
    else
    begin
      pwm_cnt <= (pwm_cnt == 4) ? 0 : pwm_cnt + 1;
      sense.tick <= (pwm_cnt == 4);
      sense.dc <= dc_lvl;
      sense.ac <= pol ? (~ac_amp + 12'h001) : ac_amp;
      if (pwm_cnt == 4)
      begin
        half_cnt <= (half_cnt == 19) ? 0 : half_cnt + 1;
        if (half_cnt == 19)
          pol <= ~pol;
      end
    end
  end
endmodule : pfm_sense_model

// ==== tb/pfm_monitor_tb.sv ====
// Self-checking bench of the PFC fault monitor.
module pfm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk;
  logic                  resetn;
  pfm_pkg::pfm_bus_req_t bus;
  pfm_pkg::pfm_sense_t   sense;
  logic [15:0]           rdata;
  logic [15:0]           rd_v;
  logic [11:0]           dc_lvl;
  logic [11:0]           ac_amp;
  logic                  mf;
  logic                  run;
  logic                  irq;
  int                    n_errors;
  int                    checked;
  pfm_monitor #(.SEQ_TICK_CYCLES(50), .PWM_HZ(2000)) pfm_monitor_inst (.CLK(clk),
    .RESETN(resetn), .BUS(bus), .RDATA(rdata), .SENSE(sense), .MOTOR_FAULT(mf),
    .PFC_RUN(run), .IRQ(irq));
  pfm_sense_model pfm_sense_model_inst (.clk(clk), .rst_n(resetn), .dc_lvl(dc_lvl),
    .ac_amp(ac_amp), .sense(sense));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(logic [7:0] a, logic [15:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic chk(logic [7:0] a, logic [15:0] e);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rd_v = rdata;
    @(posedge clk);
    cmp($sformatf("reg %h", a), e, rd_v);
  endtask : chk
  task automatic ms(int n);
    repeat (n * 50) @(posedge clk);
  endtask : ms
  task automatic t_clear_run;
    wr(8'h00, 16'h0002);
    ms(2);
    chk(8'h04, 16'h0001);
    chk(8'h08, 16'h0000);
    wr(8'h00, 16'h0001);
    ms(2);
    chk(8'h04, 16'h0002);
    cmp("run", 16'h0001, {15'h0, run});
  endtask : t_clear_run
  task automatic t_freq;
    wr(8'h00, 16'h0004);
    ms(20);
    chk(8'h08, 16'h0008);
    chk(8'h04, 16'h0003);
    wr(8'h00, 16'h0002);
    ms(2);
    chk(8'h04, 16'h0001);
  endtask : t_freq
  task automatic t_dc_uv;
    dc_lvl <= 12'h100;
    ms(20);
    chk(8'h08, 16'h0002);
    chk(8'h10, 16'h0002);
    chk(8'h04, 16'h0003);
    cmp("run", 16'h0000, {15'h0, run});
    wr(8'h00, 16'h0002);
    ms(2);
    chk(8'h04, 16'h0003);
    chk(8'h30, 16'h0007);
    wr(8'h30, 16'h0007);
    chk(8'h30, 16'h0000);
    dc_lvl <= 12'h800;
    ms(20);
    wr(8'h00, 16'h0002);
    ms(2);
    chk(8'h04, 16'h0001);
  endtask : t_dc_uv
  task automatic t_dc_ov_masked;
    wr(8'h0C, 16'h0032);
    wr(8'h00, 16'h0001);
    dc_lvl <= 12'hF00;
    ms(20);
    chk(8'h08, 16'h0004);
    chk(8'h10, 16'h0000);
    chk(8'h04, 16'h0002);
    chk(8'h14, 16'h0F00);
    chk(8'h18, 16'h0F00);
    mf <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("run", 16'h0000, {15'h0, run});
    mf <= 1'b0;
  endtask : t_dc_ov_masked
  task automatic t_ac_ov_irq;
    wr(8'h34, 16'h0001);
    ac_amp <= 12'h700;
    ms(20);
    chk(8'h08, 16'h0024);
    chk(8'h04, 16'h0003);
    cmp("irq", 16'h0001, {15'h0, irq});
    wr(8'h30, 16'h0007);
    cmp("irq", 16'h0000, {15'h0, irq});
  endtask : t_ac_ov_irq
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    resetn = 1'b0;
    bus = '0;
    dc_lvl = 12'h800;
    ac_amp = 12'h300;
    mf = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    ms(120);
    t_clear_run();
    t_freq();
    t_dc_uv();
    t_dc_ov_masked();
    t_ac_ov_irq();
    tally_and_finish();
  end
endmodule : pfm_monitor_tb
